// File: core/system_clock_source_select.sv
`default_nettype none
module system_clock_source_select
	import clock_select_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic direct_clock_input,
	input wire logic crystal_input,
	input wire logic internal_clock_input,
	input wire logic loop_clock_input,
	input wire logic wakeup_clock_input,
	input wire system_config_word_s system_config_word,
	input wire loop_config_word_s loop_config_word,
	output logic sys_clk,
	output logic [1:0] active_select,
	output logic switching,
	output logic [FACTOR_W-1:0] prescaler_factor,
	output logic [LOOP_NUM_W-1:0] loop_factor_num,
	output logic [LOOP_DEN_W-1:0] loop_factor_den
);
	switch_state_e state;
	switch_state_e next_state;
	system_config_word_s active;
	logic osc;
	logic div_out;
	logic src;
	logic new_low;
	logic next_sys_clk;
	logic [LOOP_IN_W:0] in_div;
	logic [LOOP_OUT_W:0] out_div;

	assign osc = active.prescaler_from_internal ? internal_clock_input : crystal_input;

	prescaler_divider divider (
		.clk(clk),
		.nrst(nrst),
		.osc(osc),
		.restart(state == ST_ALIGN),
		.factor(prescaler_factor_of(active.prescaler_divide_field)),
		.out_clk(div_out)
	);

	// the selected source, one cycle ahead of sys_clk
	always_comb begin
		case (active.clock_source_select)
			SEL_DIRECT: src = direct_clock_input;
			SEL_LOOP: src = active.vco_bypass ? div_out : loop_clock_input;
			SEL_WAKEUP: src = wakeup_clock_input;
			default: src = 1'b0;
		endcase
	end

	// divider restarts only with osc low, so its first edge is a rising one;
	// this holds for every source, so an oscillator stuck high also stalls a switch
	assign new_low = !src && !osc;

	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (system_config_word != active) begin
					next_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (!sys_clk) begin
					next_state = ST_ALIGN;
				end
			end
			ST_ALIGN: begin
				if (new_low) begin
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_RUN;
		endcase
	end

	// drain lets a high phase finish but never starts one; align holds low
	always_comb begin
		case (state)
			ST_RUN: next_sys_clk = src;
			ST_DRAIN: next_sys_clk = sys_clk & src;
			ST_ALIGN: next_sys_clk = 1'b0;
			default: next_sys_clk = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_RUN;
			switching <= 1'b0;
		end else begin
			state <= next_state;
			switching <= next_state != ST_RUN;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sys_clk <= 1'b0;
		end else begin
			sys_clk <= next_sys_clk;
		end
	end

	// new settings take hold only while the output is parked low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			active <= CONFIG_RESET;
			active_select <= CONFIG_RESET.clock_source_select;
			prescaler_factor <= FACTOR_ONE;
		end else if (state == ST_DRAIN && !sys_clk) begin
			active <= system_config_word;
			active_select <= system_config_word.clock_source_select;
			prescaler_factor <= prescaler_factor_of(system_config_word.prescaler_divide_field);
		end
	end

	// the analog loop is outside; its factor is reported for software
	assign in_div = {1'b0, loop_config_word.loop_input_divide_field} + 5'h01;
	assign out_div = {1'b0, loop_config_word.loop_output_divide_field} + 8'h01;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			loop_factor_num <= '0;
			loop_factor_den <= '0;
		end else begin
			loop_factor_num <= {1'b0, loop_config_word.loop_multiply_field} + 9'h001;
			loop_factor_den <= LOOP_DEN_W'(in_div * out_div);
		end
	end

	property p_direct;
		@(posedge clk) disable iff (!nrst)
		state == ST_RUN && active.clock_source_select == SEL_DIRECT
			|=> sys_clk == $past(direct_clock_input);
	endproperty
	a_direct: assert property (p_direct) else $error("direct drive not followed");

	property p_loop;
		@(posedge clk) disable iff (!nrst)
		state == ST_RUN && active.clock_source_select == SEL_LOOP && !active.vco_bypass
			|=> sys_clk == $past(loop_clock_input);
	endproperty
	a_loop: assert property (p_loop) else $error("loop clock not followed");

	property p_wakeup;
		@(posedge clk) disable iff (!nrst)
		state == ST_RUN && active.clock_source_select == SEL_WAKEUP
			|=> sys_clk == $past(wakeup_clock_input);
	endproperty
	a_wakeup: assert property (p_wakeup) else $error("wakeup clock not followed");

	property p_prescale;
		@(posedge clk) disable iff (!nrst)
		state == ST_RUN && is_prescaler(active) |=> sys_clk == $past(div_out);
	endproperty
	a_prescale: assert property (p_prescale) else $error("prescaler not followed");

	property p_no_rise_switch;
		@(posedge clk) disable iff (!nrst)
		state != ST_RUN |=> !$rose(sys_clk);
	endproperty
	a_no_rise_switch: assert property (p_no_rise_switch) else $error("rise during switch");

	property p_drain_to_align;
		@(posedge clk) disable iff (!nrst)
		state == ST_DRAIN && !sys_clk |=> state == ST_ALIGN && switching && !sys_clk;
	endproperty
	a_drain_to_align: assert property (p_drain_to_align) else $error("drain did not park");

	property p_factor_report;
		@(posedge clk) disable iff (!nrst)
		$fell(switching) |-> prescaler_factor
			== {1'b0, system_config_word.prescaler_divide_field} + FACTOR_ONE;
	endproperty
	a_factor_report: assert property (p_factor_report) else $error("factor not field+1");

	property p_loop_factor;
		@(posedge clk) disable iff (!nrst)
		$past(nrst) && $stable(loop_config_word) |->
			loop_factor_num == {1'b0, loop_config_word.loop_multiply_field} + 9'h001
			&& loop_factor_den == ({1'b0, loop_config_word.loop_input_divide_field} + 5'h01)
			* ({1'b0, loop_config_word.loop_output_divide_field} + 8'h01);
	endproperty
	a_loop_factor: assert property (p_loop_factor) else $error("loop factor wrong");

	property p_reserved;
		@(posedge clk) disable iff (!nrst)
		state == ST_RUN && active.clock_source_select == SEL_RESERVED |=> !sys_clk;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved select not parked low");

	property p_switch_start;
		@(posedge clk) disable iff (!nrst)
		state == ST_RUN && system_config_word != active |=> state == ST_DRAIN && switching;
	endproperty
	a_switch_start: assert property (p_switch_start) else $error("config change not taken");

	property p_active_hold;
		@(posedge clk) disable iff (!nrst)
		state != ST_DRAIN |=> active == $past(active);
	endproperty
	a_active_hold: assert property (p_active_hold) else $error("config moved outside drain");

	property p_align_exit;
		@(posedge clk) disable iff (!nrst)
		$fell(switching) |-> !sys_clk && $past(src) == 1'b0 && $past(osc) == 1'b0;
	endproperty
	a_align_exit: assert property (p_align_exit) else $error("switch ended off a low phase");
endmodule
`default_nettype wire

// File: core/clock_select_pkg.sv
`default_nettype none
package clock_select_pkg;
	localparam logic [1:0] SEL_WAKEUP = 2'h0;
	localparam logic [1:0] SEL_RESERVED = 2'h1;
	localparam logic [1:0] SEL_LOOP = 2'h2;
	localparam logic [1:0] SEL_DIRECT = 2'h3;
	localparam int DIVIDE_W = 10;
	localparam int FACTOR_W = 11;
	localparam int COUNT_W = 11;
	localparam int LOOP_IN_W = 4;
	localparam int LOOP_MUL_W = 8;
	localparam int LOOP_OUT_W = 7;
	localparam int LOOP_NUM_W = LOOP_MUL_W + 1;
	localparam int LOOP_DEN_W = LOOP_IN_W + LOOP_OUT_W + 2;
	localparam logic [FACTOR_W-1:0] FACTOR_ONE = 11'h001;
	localparam logic [FACTOR_W-1:0] FACTOR_MAX = 11'h400;

	typedef struct packed {
		logic [1:0] clock_source_select;
		logic vco_bypass;
		logic prescaler_from_internal;
		logic [DIVIDE_W-1:0] prescaler_divide_field;
	} system_config_word_s;

	typedef struct packed {
		logic [LOOP_IN_W-1:0] loop_input_divide_field;
		logic [LOOP_MUL_W-1:0] loop_multiply_field;
		logic [LOOP_OUT_W-1:0] loop_output_divide_field;
	} loop_config_word_s;

	localparam system_config_word_s CONFIG_RESET = '{SEL_WAKEUP, 1'b0, 1'b0, 10'h000};

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_DRAIN = 3'b010,
		ST_ALIGN = 3'b100
	} switch_state_e;

	function automatic logic [FACTOR_W-1:0] prescaler_factor_of(
		input logic [DIVIDE_W-1:0] field);
		prescaler_factor_of = {1'b0, field} + FACTOR_ONE;
	endfunction

	function automatic logic is_prescaler(input system_config_word_s cfg);
		is_prescaler = (cfg.clock_source_select == SEL_LOOP) && cfg.vco_bypass;
	endfunction
endpackage
`default_nettype wire

// File: core/prescaler_divider.sv
`default_nettype none
module prescaler_divider
	import clock_select_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic osc,
	input wire logic restart,
	input wire logic [FACTOR_W-1:0] factor,
	output logic out_clk
);
	logic osc_prev;
	logic [COUNT_W-1:0] cnt;
	logic [COUNT_W-1:0] last;
	logic [COUNT_W-1:0] next_cnt;
	logic [FACTOR_W:0] doubled;
	logic osc_edge;
	// reset parks the count on the wrap of the reset factor of one, as a restart does,
	// so the first osc rise after reset starts a high phase instead of a low one
	localparam logic [COUNT_W-1:0] CNT_RESET = 11'h001;

	// both osc edges are counted so the output keeps a half-period grid
	assign doubled = {factor, 1'b0};
	assign last = COUNT_W'(doubled - 12'h001);
	assign next_cnt = (cnt == last) ? '0 : COUNT_W'(cnt + 11'h001);
	assign osc_edge = osc != osc_prev;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			osc_prev <= 1'b0;
		end else begin
			osc_prev <= osc;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= CNT_RESET;
		end else if (restart) begin
			cnt <= last;
		end else if (osc_edge) begin
			cnt <= next_cnt;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_clk <= 1'b0;
		end else if (restart) begin
			out_clk <= 1'b0;
		end else if (osc_edge) begin
			out_clk <= next_cnt < COUNT_W'(factor);
		end
	end

	property p_count_bound;
		@(posedge clk) disable iff (!nrst)
		!restart |-> cnt <= last && factor <= FACTOR_MAX;
	endproperty
	a_count_bound: assert property (p_count_bound) else $error("divider count past 2*factor-1");

	property p_rise_on_wrap;
		@(posedge clk) disable iff (!nrst)
		$rose(out_clk) |-> cnt == '0 && $past(osc_edge) && $past(cnt) == $past(last);
	endproperty
	a_rise_on_wrap: assert property (p_rise_on_wrap) else $error("divided clock rose off the wrap");

	property p_factor_one;
		@(posedge clk) disable iff (!nrst)
		(factor == FACTOR_ONE && !restart) ##1 !restart |-> out_clk == $past(osc);
	endproperty
	a_factor_one: assert property (p_factor_one) else $error("factor one did not pass osc");
endmodule
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import clock_select_pkg::*;
	logic clk, nrst, direct_clock_input, crystal_input, internal_clock_input;
	logic loop_clock_input, wakeup_clock_input, sys_clk, switching;
	system_config_word_s cfg;
	loop_config_word_s lcfg;
	logic [1:0] active_select;
	logic [FACTOR_W-1:0] prescaler_factor;
	logic [LOOP_NUM_W-1:0] loop_factor_num;
	logic [LOOP_DEN_W-1:0] loop_factor_den;
	int fail_count, total_checks, tick, cycles;

	system_clock_source_select dut_u (
		.clk(clk),
		.nrst(nrst),
		.direct_clock_input(direct_clock_input),
		.crystal_input(crystal_input),
		.internal_clock_input(internal_clock_input),
		.loop_clock_input(loop_clock_input),
		.wakeup_clock_input(wakeup_clock_input),
		.system_config_word(cfg),
		.loop_config_word(lcfg),
		.sys_clk(sys_clk),
		.active_select(active_select),
		.switching(switching),
		.prescaler_factor(prescaler_factor),
		.loop_factor_num(loop_factor_num),
		.loop_factor_den(loop_factor_den)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// distinct half periods per source so a wrong selection shows up as a wrong period
	always @(posedge clk) begin
		#1;
		tick++;
		cycles++;
		direct_clock_input = ((tick / 4) % 2) == 1;
		crystal_input = ((tick / 2) % 2) == 1;
		internal_clock_input = ((tick / 3) % 2) == 1;
		loop_clock_input = (tick % 2) == 1;
		wakeup_clock_input = ((tick / 5) % 2) == 1;
		if (cycles >= 60000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// cycles to the next rising edge of sys_clk, and how many of them were high
	task automatic wait_rise(output int n, output int h);
		logic prev;
		n = 0;
		h = 0;
		prev = sys_clk;
		while (n < 10000) begin
			@(posedge clk);
			#2;
			n++;
			if (prev === 1'b1)
				h++;
			if (prev === 1'b0 && sys_clk === 1'b1)
				break;
			prev = sys_clk;
		end
	endtask

	// reserved select parks the system clock low
	task automatic park_reserved();
		int n, h;
		@(posedge clk);
		#1;
		cfg = '{SEL_RESERVED, 1'b0, 1'b0, 10'h000};
		@(posedge clk);
		#2;
		chk(switching, 1);
		n = 0;
		while (switching !== 1'b0 && n < 100) begin
			@(posedge clk);
			#2;
			n++;
		end
		chk(switching, 0);
		chk(active_select, SEL_RESERVED);
		h = 0;
		repeat (40) begin
			@(posedge clk);
			#2;
			if (sys_clk !== 1'b0)
				h++;
		end
		chk(h, 0);
	endtask

	task automatic check_reset();
		chk(sys_clk, 0);
		chk(active_select, SEL_WAKEUP);
		chk(switching, 0);
		chk(prescaler_factor, FACTOR_ONE);
		chk(loop_factor_num, 0);
		chk(loop_factor_den, 0);
	endtask

	task automatic loop_factor(input loop_config_word_s c, input int num, input int den);
		@(posedge clk);
		#1;
		lcfg = c;
		@(posedge clk);
		#2;
		chk(loop_factor_num, num[LOOP_NUM_W-1:0]);
		chk(loop_factor_den, den[LOOP_DEN_W-1:0]);
	endtask

	// apply a config, ride out the switch, then judge one full sys_clk period
	task automatic measure(input system_config_word_s c, input logic [1:0] sel,
		input logic [FACTOR_W-1:0] fac, input int per, input int hi);
		int n, h;
		@(posedge clk);
		#1;
		cfg = c;
		n = 0;
		while (switching !== 1'b1 && n < 8) begin
			@(posedge clk);
			#2;
			n++;
		end
		chk(switching, 1);
		n = 0;
		while (switching !== 1'b0 && n < 20000) begin
			@(posedge clk);
			#2;
			n++;
		end
		chk(switching, 0);
		chk(active_select, sel);
		chk(prescaler_factor, fac);
		wait_rise(n, h);
		wait_rise(n, h);
		wait_rise(n, h);
		chk(n, per);
		chk(h, hi);
	endtask

	initial begin
		nrst = 1'b0;
		cfg = CONFIG_RESET;
		lcfg = '0;
		repeat (2) @(posedge clk);
		#1;
		check_reset();
		nrst = 1'b1;
		loop_factor('{4'h2, 8'h0B, 7'h04}, 12, 15);
		loop_factor('{4'hF, 8'hFF, 7'h7F}, 256, 2048);
		measure('{SEL_DIRECT, 1'b0, 1'b0, 10'h000}, SEL_DIRECT, 11'h001, 8, 4);
		measure('{SEL_LOOP, 1'b1, 1'b0, 10'h000}, SEL_LOOP, 11'h001, 4, 2);
		measure('{SEL_LOOP, 1'b1, 1'b0, 10'h002}, SEL_LOOP, 11'h003, 12, 6);
		measure('{SEL_LOOP, 1'b1, 1'b1, 10'h001}, SEL_LOOP, 11'h002, 12, 6);
		measure('{SEL_LOOP, 1'b1, 1'b0, 10'h3FF}, SEL_LOOP, 11'h400, 4096, 2048);
		measure('{SEL_LOOP, 1'b0, 1'b0, 10'h3FF}, SEL_LOOP, 11'h400, 2, 1);
		measure('{SEL_WAKEUP, 1'b0, 1'b0, 10'h000}, SEL_WAKEUP, 11'h001, 10, 5);
		park_reserved();
		// a second reset mid-run must bring every output back to its idle value
		measure('{SEL_DIRECT, 1'b0, 1'b0, 10'h005}, SEL_DIRECT, 11'h006, 8, 4);
		@(posedge clk);
		#1;
		nrst = 1'b0;
		@(posedge clk);
		#1;
		check_reset();
		nrst = 1'b1;
		// the word still differs from the reset config, so a switch starts by itself
		measure('{SEL_DIRECT, 1'b0, 1'b0, 10'h005}, SEL_DIRECT, 11'h006, 8, 4);
		tally_and_finish();
	end
endmodule
`default_nettype wire
